//--- design/rms_pkg.sv
// Purpose: constants for the miscellaneous syndrome bank (registers b, c, d)
// Assumes: 64-byte record stride, 64-bit registers, one clock
// Notes: field layout inside the syndrome words is local to this bank
//
// Contract
// - register b exists only for implemented records; otherwise reads zero, ignores writes
// - registers c and d exist for implemented records with v1.1, else optional
// - writing zero to syndrome fields returns record to quiescent state
// - writing zero to an interrupt-raising field drops that interrupt request
// - read-only nonzero fields ignoring writes count as quiescent
// - interrupt-raising fields disabled at cold reset; node control enables them
// - 64-bit system view addresses the record held in the selector
// - 32-bit view splits each register into low and high half accessors
// - memory view decodes b, c, d at 0x028, 0x030, 0x038 plus 64 per record
// - with timestamp support, register d holds capture-time timestamp
// - with fault injection and capability bit, protected parts writable while misc-valid
// - accumulating syndrome such as corrected counter is read/write
// - while misc-valid set, latest-error syndrome ignores writes
// - without v1.1, registers c and d need no zeroing for quiescence
// - record features come from the node's first owned record
// - unlaid-out bits are implementation syndrome with local behaviour
// - timestamp is meaningful only while record valid flag is set
// - syndrome contents kept across error recovery reset
package rms_pkg;
  // ==========================================================
  // memory-mapped layout
  localparam int REC_SHIFT = 6;
  localparam logic [5:0] OFF_MISC_B = 6'h28;
  localparam logic [5:0] OFF_MISC_C = 6'h30;
  localparam logic [5:0] OFF_MISC_D = 6'h38;
  // ==========================================================
  // register selectors and half accessors
  localparam logic [1:0] REG_B = 2'h0;
  localparam logic [1:0] REG_C = 2'h1;
  localparam logic [1:0] REG_D = 2'h2;
  localparam logic [1:0] REG_NONE = 2'h3;
  localparam logic [2:0] HALF_LAST = 3'h5;
  // ==========================================================
  // field layout of the syndrome words
  localparam int CNT_LSB = 0;
  localparam int CNT_W = 16;
  localparam int OVF_BIT = 16;
  localparam int LOC_LSB = 17;
  localparam int LOC_W = 47;
  localparam int SYN_W = 48;
  localparam int FIX_LSB = 48;
  localparam logic [63:0] ACC_MASK = 64'h0000_0000_0001_ffff;
  localparam logic [63:0] C_RW_MASK = 64'h0000_ffff_ffff_ffff;
  localparam logic [15:0] C_FIX_VAL = 16'h5a5a;
  localparam logic [63:0] ALL_ONES = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] LO_MASK = 64'h0000_0000_ffff_ffff;
  localparam logic [1:0] TS_NONE = 2'h0;
endpackage : rms_pkg

//--- design/rms_bank.sv
// Purpose: miscellaneous syndrome registers b, c, d for all records of the bank, grouped into nodes of RPN records
// Assumes: all inputs synchronous to clk; one write port wins per cycle, while all three views can read in the same cycle
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/1ns
module rms_bank
  import rms_pkg::*;
#(
  parameter int NREC = 4,
  parameter int RPN = 2,
  parameter logic V11 = 1'b1,
  parameter logic [NREC-1:0] IMPL_MASK = '1,
  parameter logic [NREC-1:0] CD_MASK = '1
) (
  // clock and resets
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic err_rec_rst,
  // node status and features, one bit or field per record
  input wire logic [NREC-1:0] misc_valid_status_flag,
  input wire logic [NREC-1:0] rec_valid,
  input wire logic [2*NREC-1:0] timestamp_support_field,
  input wire logic [NREC-1:0] node_inj_impl,
  input wire logic [NREC-1:0] injection_misc_valid_capability,
  input wire logic [NREC-1:0] ctrl_irq_en,
  // error capture from the detecting logic
  input wire logic err_log,
  input wire logic err_ce,
  input wire logic [$clog2(NREC)-1:0] err_rec,
  input wire logic [LOC_W-1:0] err_loc,
  input wire logic [SYN_W-1:0] err_syn,
  input wire logic [63:0] err_impl_d,
  input wire logic [63:0] ts_now,
  // 64-bit system register view
  input wire logic [$clog2(NREC)-1:0] record_selector_field,
  input wire logic sys_rd,
  input wire logic sys_wr,
  input wire logic [1:0] sys_reg,
  input wire logic [63:0] sys_wdata,
  output logic [63:0] sys_rdata,
  // 32-bit half accessor view
  input wire logic [$clog2(NREC)-1:0] record_selector_field_32,
  input wire logic s32_rd,
  input wire logic s32_wr,
  input wire logic [2:0] s32_half,
  input wire logic [31:0] s32_wdata,
  output logic [31:0] s32_rdata,
  // memory-mapped view
  input wire logic mm_rd,
  input wire logic mm_wr,
  input wire logic [REC_SHIFT+$clog2(NREC)-1:0] mm_addr,
  input wire logic [63:0] mm_wdata,
  output logic [63:0] mm_rdata,
  // fault handling interrupt request
  output logic fault_irq_req
);
  localparam int RW = $clog2(NREC);
  localparam int NE = NREC * 3;
  localparam int EW = $clog2(NE);
  localparam int ABITS = REC_SHIFT + RW;

  // ==========================================================
  // helpers
  function automatic logic [EW-1:0] idx(input int r, input int k);
    return EW'(r * 3 + k);
  endfunction : idx

  function automatic logic present(input int r, input int k);
    return (r < NREC) && (k < 3) && IMPL_MASK[r] && (k == 0 || V11 || CD_MASK[r]);
  endfunction : present

  function automatic int first_of(input int r);
    return (r / RPN) * RPN;
  endfunction : first_of

  function automatic logic ts_on(input int r);
    return timestamp_support_field[2*first_of(r) +: 2] != TS_NONE;
  endfunction : ts_on

  logic [63:0] mem_q [NE];
  logic [63:0] mem_d [NE];
  logic [63:0] view [NE];
  logic [63:0] sys_rdata_q;
  logic [31:0] s32_rdata_q;
  logic [63:0] mm_rdata_q;
  logic irq_q;

  // ==========================================================
  // address decode for the three views
  wire logic [RW-1:0] mm_rec = mm_addr[ABITS-1:REC_SHIFT];
  wire logic [5:0] mm_off = mm_addr[REC_SHIFT-1:0];
  wire logic [1:0] mm_k = (mm_off == OFF_MISC_B) ? REG_B :
                          (mm_off == OFF_MISC_C) ? REG_C :
                          (mm_off == OFF_MISC_D) ? REG_D : REG_NONE;
  wire logic mm_hit = present(int'(mm_rec), int'(mm_k));
  wire logic [EW-1:0] mm_idx = idx(int'(mm_rec), int'(mm_k));
  wire logic sys_hit = present(int'(record_selector_field), int'(sys_reg));
  wire logic [EW-1:0] sys_idx = idx(int'(record_selector_field), int'(sys_reg));
  wire logic [1:0] s32_k = (s32_half > HALF_LAST) ? REG_NONE : s32_half[2:1];
  wire logic s32_hi = s32_half[0];
  wire logic s32_hit = present(int'(record_selector_field_32), int'(s32_k));
  wire logic [EW-1:0] s32_idx = idx(int'(record_selector_field_32), int'(s32_k));

  // ==========================================================
  // write arbitration: memory view, then 64-bit, then 32-bit
  // simultaneous writes from two views lose the lower one; software serialises
  wire logic mm_we = mm_wr & mm_hit;
  wire logic sys_we = sys_wr & sys_hit;
  wire logic s32_we = s32_wr & s32_hit;
  wire logic wr_en = mm_we | sys_we | s32_we;
  wire logic [EW-1:0] wr_idx = mm_we ? mm_idx : sys_we ? sys_idx : s32_idx;
  wire logic [63:0] s32_wide = s32_hi ? {s32_wdata, 32'h0000_0000} : {32'h0000_0000, s32_wdata};
  wire logic [63:0] s32_mask = s32_hi ? ~LO_MASK : LO_MASK;
  wire logic [63:0] wr_data = mm_we ? mm_wdata : sys_we ? sys_wdata : s32_wide;
  wire logic [63:0] wr_bmask = (mm_we | sys_we) ? ALL_ONES : s32_mask;

  // ==========================================================
  // next state of every syndrome word
  always_comb begin
    logic [63:0] base;
    logic [63:0] wm;
    logic [CNT_W:0] cnt;
    logic prot;
    int q;
    base = '0;
    wm = '0;
    cnt = '0;
    prot = 1'b0;
    q = 0;
    for (int r = 0; r < NREC; r++) begin
      for (int k = 0; k < 3; k++) begin
        base = mem_q[r*3+k];
        q = first_of(r);
        // latest-error syndrome frozen while misc-valid, unless injection opens it
        prot = misc_valid_status_flag[r] &
               ~(node_inj_impl[q] & injection_misc_valid_capability[q]);
        if (k == 0) begin
          wm = prot ? ACC_MASK : ALL_ONES;
        end else if (k == 1) begin
          wm = prot ? '0 : C_RW_MASK;
        end else begin
          wm = prot ? '0 : ALL_ONES;
        end
        // software write; zero clears counter and overflow, quiescing the record
        if (wr_en && wr_idx == idx(r, k)) begin
          base = (base & ~(wr_bmask & wm)) | (wr_data & wr_bmask & wm);
        end
        // hardware capture of a newly recorded error
        if (err_log && int'(err_rec) == r) begin
          if (k == 0) begin
            base[LOC_LSB +: LOC_W] = err_loc;
          end else if (k == 1) begin
            base[SYN_W-1:0] = err_syn;
          end else begin
            base = ts_on(r) ? ts_now : err_impl_d;
          end
        end
        // corrected count lands after a same-cycle write, so no event is lost
        if (k == 0 && err_ce && int'(err_rec) == r) begin
          cnt = {1'b0, base[CNT_LSB +: CNT_W]} + {{CNT_W{1'b0}}, 1'b1};
          base[CNT_LSB +: CNT_W] = cnt[CNT_W-1:0];
          if (cnt[CNT_W]) begin
            base[OVF_BIT] = 1'b1;
          end
        end
        if (k == 1) begin
          base[63:FIX_LSB] = C_FIX_VAL;
        end
        mem_d[r*3+k] = present(r, k) ? base : '0;
      end
    end
  end

  // ==========================================================
  // read view: absent words zero, stale timestamp hidden
  always_comb begin
    for (int r = 0; r < NREC; r++) begin
      for (int k = 0; k < 3; k++) begin
        if (!present(r, k) || (k == 2 && ts_on(r) && !rec_valid[r])) begin
          view[r*3+k] = '0;
        end else if (k == 1) begin
          // fixed top shown even in the first cycle after cold reset
          view[r*3+k] = {C_FIX_VAL, mem_q[r*3+k][FIX_LSB-1:0]};
        end else begin
          view[r*3+k] = mem_q[r*3+k];
        end
      end
    end
  end

  wire logic [63:0] sys_val = sys_hit ? view[sys_idx] : '0;
  wire logic [63:0] s32_word = s32_hit ? view[s32_idx] : '0;
  wire logic [31:0] s32_val = s32_hi ? s32_word[63:32] : s32_word[31:0];
  wire logic [63:0] mm_val = mm_hit ? view[mm_idx] : '0;

  // interrupt: counter overflow of b, gated by the node enable
  // c and d carry no request source, so quiescence never needs them zeroed
  logic irq_any;
  always_comb begin
    irq_any = 1'b0;
    for (int r = 0; r < NREC; r++) begin
      irq_any = irq_any | (mem_q[r*3][OVF_BIT] & ctrl_irq_en[first_of(r)]);
    end
  end

  // ==========================================================
  // storage; error recovery reset deliberately leaves it alone
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int e = 0; e < NE; e++) begin
        mem_q[e] <= '0;
      end
    end else begin
      for (int e = 0; e < NE; e++) begin
        mem_q[e] <= mem_d[e];
      end
    end
  end

  // read data and interrupt flops
  always_ff @(posedge clk) begin
    if (sys_rst || err_rec_rst) begin
      sys_rdata_q <= '0;
      s32_rdata_q <= '0;
      mm_rdata_q <= '0;
      irq_q <= 1'b0;
    end else begin
      if (sys_rd) sys_rdata_q <= sys_val;
      if (s32_rd) s32_rdata_q <= s32_val;
      if (mm_rd) mm_rdata_q <= mm_val;
      irq_q <= irq_any;
    end
  end

  assign sys_rdata = sys_rdata_q;
  assign s32_rdata = s32_rdata_q;
  assign mm_rdata = mm_rdata_q;
  assign fault_irq_req = irq_q;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire logic wr_b_zero = wr_en && (wr_data & wr_bmask) == '0 && wr_bmask == ALL_ONES
                         && wr_idx % 3 == 0;
  wire logic no_event = !err_ce && !err_log;
  wire logic [EW-1:0] d_idx = idx(int'(err_rec), 2);
  wire logic [EW-1:0] b_idx = idx(int'(err_rec), 0);
  // record of the winning write; the error record index says nothing about it
  wire logic [RW-1:0] wr_rec = RW'(wr_idx / 3);
  // a half write that no wider view overrides
  wire logic s32_alone = s32_we && !mm_we && !sys_we;
  wire logic sel_ts = ts_on(int'(record_selector_field));
  // read data flops are cleared by the recovery reset, so reads beside it prove nothing
  wire logic quiet_rst = !err_rec_rst;

  // overflow flags of every record, gathered without the node enable
  logic [NREC-1:0] ovf_vec;
  always_comb begin
    for (int r = 0; r < NREC; r++) begin
      ovf_vec[r] = mem_q[r*3][OVF_BIT];
    end
  end

  // presence and decode of the three views
  absent_read_zero_a: assert property (mm_rd && !mm_hit |=> mm_rdata == '0)
    else $error("absent register read not zero");
  cd_present_a: assert property (
    V11 && sys_rd && IMPL_MASK[record_selector_field] && sys_reg != REG_NONE |-> sys_hit)
    else $error("register c or d missing under v1.1");
  sys_none_a: assert property (
    sys_rd && quiet_rst && sys_reg == REG_NONE |=> sys_rdata == '0)
    else $error("unused system selector read not zero");
  rdata_hold_a: assert property (
    !sys_rd && quiet_rst |=> $stable(sys_rdata))
    else $error("system read data moved without a read");
  mm_decode_a: assert property (
    mm_rd && quiet_rst && mm_addr[REC_SHIFT-1:0] == OFF_MISC_B
    |=> mm_rdata == $past(mem_q[3 * int'(mm_addr[ABITS-1:REC_SHIFT])]))
    else $error("memory view read mismatch");
  s32_none_a: assert property (
    s32_rd && quiet_rst && s32_half > HALF_LAST |=> s32_rdata == '0)
    else $error("unused half accessor read not zero");
  half_split_a: assert property (
    s32_rd && quiet_rst && s32_hit && s32_hi |=> s32_rdata == $past(s32_word[63:32]))
    else $error("high half accessor wrong");
  half_keep_a: assert property (
    s32_alone && !s32_hi && no_event
    |=> mem_q[$past(wr_idx)][47:32] == $past(mem_q[wr_idx][47:32]))
    else $error("low half write disturbed the high half");

  // quiescence and the interrupt request
  zero_write_quiet_a: assert property (
    wr_b_zero && no_event |=> mem_q[$past(wr_idx)][OVF_BIT] == 1'b0)
    else $error("zero write left overflow set");
  irq_drop_a: assert property (ovf_vec == '0 |=> !fault_irq_req)
    else $error("interrupt request without an overflow");
  irq_gate_a: assert property (ctrl_irq_en == '0 [*2] |-> !fault_irq_req)
    else $error("interrupt without enable");
  fixed_field_a: assert property (
    sys_rd && quiet_rst && sys_hit && sys_reg == REG_C
    |=> sys_rdata[63:FIX_LSB] == C_FIX_VAL)
    else $error("fixed field not constant");

  // capture, protection and recovery reset
  ts_capture_a: assert property (
    err_log && ts_on(int'(err_rec)) && present(int'(err_rec), 2)
    |=> mem_q[$past(d_idx)] == $past(ts_now))
    else $error("timestamp not captured");
  ts_hide_a: assert property (
    sys_rd && quiet_rst && sys_reg == REG_D && sel_ts && !rec_valid[record_selector_field]
    |=> sys_rdata == '0)
    else $error("stale timestamp visible");
  loc_capture_a: assert property (
    err_log && present(int'(err_rec), 0)
    |=> mem_q[$past(b_idx)][63:LOC_LSB] == $past(err_loc))
    else $error("error location not captured");
  counter_rw_a: assert property (
    wr_en && wr_idx % 3 == 0 && wr_bmask == ALL_ONES && no_event
    |=> mem_q[$past(wr_idx)][CNT_W-1:0] == $past(wr_data[CNT_W-1:0]))
    else $error("counter not writable");
  ce_wrap_a: assert property (
    err_ce && !wr_en && mem_q[b_idx][CNT_W-1:0] == '1 |=> mem_q[$past(b_idx)][OVF_BIT])
    else $error("counter wrap did not set overflow");
  protect_a: assert property (
    wr_en && wr_idx % 3 == 0 && misc_valid_status_flag[wr_rec]
    && !node_inj_impl[first_of(int'(wr_rec))] && no_event
    |=> mem_q[$past(wr_idx)][63:LOC_LSB] == $past(mem_q[wr_idx][63:LOC_LSB]))
    else $error("protected syndrome overwritten");
  inject_open_a: assert property (
    wr_en && wr_idx % 3 == 0 && wr_bmask == ALL_ONES && no_event
    && node_inj_impl[first_of(int'(wr_rec))]
    && injection_misc_valid_capability[first_of(int'(wr_rec))]
    |=> mem_q[$past(wr_idx)][63:LOC_LSB] == $past(wr_data[63:LOC_LSB]))
    else $error("injection left syndrome locked");
  err_rst_keep_a: assert property (
    err_rec_rst && !wr_en && no_event |=> $stable(mem_q[0]))
    else $error("error recovery reset altered syndrome");
  rec_rst_clear_a: assert property (
    err_rec_rst |=> sys_rdata == '0 && s32_rdata == '0 && mm_rdata == '0 && !fault_irq_req)
    else $error("recovery reset left read data or request standing");

  // cover points for the main scenarios
  ce_count_c: cover property (err_ce ##1 err_ce);
  overflow_irq_c: cover property ($rose(fault_irq_req) ##[1:20] !fault_irq_req);
  half_write_c: cover property (s32_wr && s32_hit ##1 s32_rd && s32_hit);
  zero_quiet_c: cover property (wr_b_zero ##1 !fault_irq_req);
  ts_hidden_c: cover property (sys_rd && sel_ts && !rec_valid[record_selector_field]);
endmodule : rms_bank

//--- bench/error_record_misc_syndrome_tb.sv
// Purpose: self-checking bench for the syndrome bank b, c, d of four records
// Assumes: two records per node, all three registers present, v1.1 build
// Notes: inputs change on the falling edge; reference model held in m
`timescale 1ns/1ns
module error_record_misc_syndrome_tb;
  import rms_pkg::*;
  // ==========================================================
  // stimulus and observed signals
  logic clk, sys_rst, err_rec_rst, err_log, err_ce;
  logic sys_rd, sys_wr, s32_rd, s32_wr, mm_rd, mm_wr, fault_irq_req;
  logic [3:0] misc_valid_status_flag, rec_valid, node_inj_impl;
  logic [3:0] injection_misc_valid_capability, ctrl_irq_en;
  logic [7:0] timestamp_support_field, mm_addr;
  logic [1:0] err_rec, record_selector_field, record_selector_field_32, sys_reg;
  logic [46:0] err_loc;
  logic [47:0] err_syn;
  logic [63:0] err_impl_d, ts_now, sys_wdata, sys_rdata, mm_wdata, mm_rdata;
  logic [2:0] s32_half;
  logic [31:0] s32_wdata, s32_rdata;
  logic [63:0] m [4][3];
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;

  rms_bank u_dut (.clk, .sys_rst, .err_rec_rst, .misc_valid_status_flag, .rec_valid,
    .timestamp_support_field, .node_inj_impl, .injection_misc_valid_capability,
    .ctrl_irq_en, .err_log, .err_ce, .err_rec, .err_loc, .err_syn, .err_impl_d, .ts_now,
    .record_selector_field, .sys_rd, .sys_wr, .sys_reg, .sys_wdata, .sys_rdata,
    .record_selector_field_32, .s32_rd, .s32_wr, .s32_half, .s32_wdata, .s32_rdata,
    .mm_rd, .mm_wr, .mm_addr, .mm_wdata, .mm_rdata, .fault_irq_req);

  // ==========================================================
  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // a stuck handshake would otherwise spin forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  // ==========================================================
  // reference model
  function automatic logic [63:0] rnd();
    return {$urandom, $urandom};
  endfunction : rnd
  // read view: c top is fixed, d hides a timestamp of a record not valid
  function automatic logic [63:0] ex(int r, int k);
    int q = r / 2 * 2;
    logic [63:0] v = m[r][k];
    if (k == 1) v = {16'h5a5a, v[47:0]};
    if (k == 2 && timestamp_support_field[2*q +: 2] != TS_NONE && !rec_valid[r]) v = '0;
    return v;
  endfunction : ex
  // protected syndrome keeps its value while misc-valid, unless injection opens it
  function automatic void mw(int r, int k, logic [63:0] w);
    int q = r / 2 * 2;
    if (misc_valid_status_flag[r] && !(node_inj_impl[q] && injection_misc_valid_capability[q])) begin
      if (k == 0) m[r][0][16:0] = w[16:0];
    end else begin
      m[r][k] = w;
    end
  endfunction : mw

  task automatic cmp(logic [63:0] got, logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // one access: v 0 system 64-bit, 1 memory map, 2 half accessor (k is the half)
  task automatic acc(int v, int r, int k, logic [63:0] w, logic is_wr);
    logic [63:0] e;
    logic [63:0] cur;
    @(negedge clk);
    record_selector_field = r[1:0];
    record_selector_field_32 = r[1:0];
    sys_reg = k[1:0];
    s32_half = k[2:0];
    mm_addr = {r[1:0], 6'(OFF_MISC_B + k * 8)};
    sys_wdata = w;
    mm_wdata = w;
    s32_wdata = w[31:0];
    sys_wr = is_wr && v == 0;
    mm_wr = is_wr && v == 1;
    s32_wr = is_wr && v == 2;
    sys_rd = !is_wr && v == 0;
    mm_rd = !is_wr && v == 1;
    s32_rd = !is_wr && v == 2;
    @(negedge clk);
    {sys_wr, mm_wr, s32_wr, sys_rd, mm_rd, s32_rd} = 6'h00;
    if (is_wr) begin
      if (v == 2 && k < 6) begin
        cur = m[r][k/2];
        mw(r, k / 2, (k % 2) ? {w[31:0], cur[31:0]} : {cur[63:32], w[31:0]});
      end else if (v != 2 && k < 3) begin
        mw(r, k, w);
      end
    end else if (v == 2) begin
      e = (k < 6) ? ((ex(r, k / 2) >> (32 * (k % 2))) & LO_MASK) : 64'h0000_0000_0000_0000;
      cmp({32'h0000_0000, s32_rdata}, e);
    end else begin
      e = (k < 3) ? ex(r, k) : 64'h0000_0000_0000_0000;
      cmp(v ? mm_rdata : sys_rdata, e);
    end
  endtask : acc

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================================
  // main sequence
  initial begin
    {sys_rst, err_rec_rst, err_log, err_ce, sys_rd, sys_wr} = 6'h20;
    {s32_rd, s32_wr, mm_rd, mm_wr} = 4'h0;
    {misc_valid_status_flag, rec_valid, node_inj_impl} = 12'h000;
    {injection_misc_valid_capability, ctrl_irq_en, timestamp_support_field} = 16'h0000;
    {err_rec, record_selector_field, record_selector_field_32, sys_reg, mm_addr} = 16'h0000;
    {err_loc, err_syn, s32_half, s32_wdata} = '0;
    {err_impl_d, ts_now, sys_wdata, mm_wdata} = '0;
    for (int r = 0; r < 4; r++) for (int k = 0; k < 3; k++) m[r][k] = '0;
    void'($urandom(59110));
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    // cold reset leaves every word clear except the fixed top of c
    for (int r = 0; r < 4; r++) for (int k = 0; k < 4; k++) acc(1, r, k, 0, 0);
    $display("test reset done");
    // cross-view writes and reads; k of 3 is the absent slot
    for (int r = 0; r < 4; r++) for (int k = 0; k < 4; k++) begin
      acc(0, r, k, rnd(), 1);
      acc(1, r, k, 0, 0);
      acc(1, r, k, rnd(), 1);
      acc(0, r, k, 0, 0);
    end
    for (int r = 0; r < 4; r++) for (int h = 0; h < 8; h++) begin
      acc(2, r, h, rnd(), 1);
      acc(2, r, h, 0, 0);
    end
    $display("test views done");
    // latest-error fields locked while misc-valid; injection opens them
    misc_valid_status_flag[3] = 1'b1;
    for (int p = 0; p < 2; p++) begin
      node_inj_impl[2] = p[0];
      injection_misc_valid_capability[2] = p[0];
      for (int k = 0; k < 3; k++) acc(1, 3, k, rnd(), 1);
      for (int k = 0; k < 3; k++) acc(0, 3, k, 0, 0);
    end
    misc_valid_status_flag[3] = 1'b0;
    $display("test protect done");
    // counter wrap raises the overflow; enable gates it; zero write drops it
    // earlier random writes may have left record 0 overflowed; it shares the enable
    acc(0, 0, 0, 0, 1);
    acc(0, 1, 0, 64'h0000_0000_0000_ffff, 1);
    @(negedge clk);
    err_rec = 2'h1;
    err_ce = 1'b1;
    @(negedge clk);
    err_ce = 1'b0;
    m[1][0][16:0] = 17'h1_0000;
    @(negedge clk);
    cmp({63'h0, fault_irq_req}, 64'h0000_0000_0000_0000);
    ctrl_irq_en[0] = 1'b1;
    repeat (2) @(negedge clk);
    cmp({63'h0, fault_irq_req}, 64'h0000_0000_0000_0001);
    acc(0, 1, 0, 0, 0);
    acc(0, 1, 0, 0, 1);
    @(negedge clk);
    cmp({63'h0, fault_irq_req}, 64'h0000_0000_0000_0000);
    $display("test irq done");
    // recovery reset keeps storage
    err_rec_rst = 1'b1;
    @(negedge clk);
    err_rec_rst = 1'b0;
    for (int r = 0; r < 4; r++) for (int k = 0; k < 3; k++) acc(1, r, k, 0, 0);
    // capture with and without timestamp support of the node's first record
    for (int t = 0; t < 2; t++) begin
      timestamp_support_field[5:4] = t ? 2'h1 : 2'h0;
      rec_valid[2] = 1'b1;
      err_rec = 2'h2;
      {err_loc, err_syn} = 95'({rnd(), rnd()});
      err_impl_d = rnd();
      ts_now = rnd();
      err_log = 1'b1;
      @(negedge clk);
      err_log = 1'b0;
      m[2][0][63:17] = err_loc;
      m[2][1][47:0] = err_syn;
      m[2][2] = t ? ts_now : err_impl_d;
      for (int k = 0; k < 3; k++) acc(0, 2, k, 0, 0);
      rec_valid[2] = 1'b0;
      acc(0, 2, 2, 0, 0);
      acc(0, 3, 2, 0, 0);
    end
    $display("test capture done");
    report_and_stop();
  end
endmodule : error_record_misc_syndrome_tb
